// ---- core/lafc_top.sv ----
// Purpose: LCD animation status, display memory control and frame counters
// Assumes: Tick inputs are one-cycle pulses synchronous to clk_i
// Notes:   Display memories live outside; this block grants writes and clears
//
// Design decisions made here: the placing of the registers and the AHB-Lite slave port.

`timescale 1ns/1ps

module lafc_top #(
  parameter int unsigned CNT_W = 16
) (
  input  wire logic        clk_i,
  input  wire logic        arst_n_i,
  // AHB-Lite
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic        hready_i,
  input  wire logic [31:0] hwdata_i,
  output logic [31:0]      hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  // Frame counter tick sources
  input  wire logic        lcd_tick_i,
  input  wire logic        rtc_tick_i,
  input  wire logic        logic1_tick_i,
  input  wire logic        logic2_tick_i,
  // Display memory control
  output logic             primary_write_grant_o,
  output logic             secondary_write_grant_o,
  output logic             primary_clear_o,
  output logic             secondary_clear_o,
  output logic             display_from_secondary_o,
  output logic             enhanced_irq_o
);

  // ***********************************************
  // Register bus
  // ***********************************************
  logic [7:0]  rd_addr;
  logic [7:0]  wr_addr;
  logic [31:0] wr_data;
  logic        wr_stb;
  logic [31:0] rd_data;

  lafc_ahb_slave u_bus (
    .clk_i       (clk_i),
    .arst_n_i    (arst_n_i),
    .hsel_i      (hsel_i),
    .haddr_i     (haddr_i),
    .htrans_i    (htrans_i),
    .hwrite_i    (hwrite_i),
    .hready_i    (hready_i),
    .hwdata_i    (hwdata_i),
    .rd_data_i   (rd_data),
    .rd_addr_o   (rd_addr),
    .wr_stb_o    (wr_stb),
    .wr_addr_o   (wr_addr),
    .wr_data_o   (wr_data),
    .hrdata_o    (hrdata_o),
    .hreadyout_o (hreadyout_o),
    .hresp_o     (hresp_o)
  );

  logic wr_stat;
  logic wr_lim0;
  logic wr_lim1;
  logic wr_lim2;
  logic wr_ctrl;
  logic wr_tevt;

  assign wr_stat = wr_stb && (wr_addr == lafc_pkg::OFS_STAT);
  assign wr_lim0 = wr_stb && (wr_addr == lafc_pkg::OFS_LIM0);
  assign wr_lim1 = wr_stb && (wr_addr == lafc_pkg::OFS_LIM1);
  assign wr_lim2 = wr_stb && (wr_addr == lafc_pkg::OFS_LIM2);
  assign wr_ctrl = wr_stb && (wr_addr == lafc_pkg::OFS_CTRL);
  assign wr_tevt = wr_stb && (wr_addr == lafc_pkg::OFS_TEVT);

  // ***********************************************
  // Software registers
  // ***********************************************
  logic [CNT_W-1:0] lim0_r;
  logic [CNT_W-1:0] lim1_r;
  logic [CNT_W-1:0] lim2_r;
  logic [15:0]      tevt_r;
  logic [16:0]      ctrl_r;
  logic [7:0]       mctl_r;

  // Limits are plain storage; writing them while enabled is the user's hazard
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      lim0_r <= CNT_W'(lafc_pkg::RST_LIM);
      lim1_r <= CNT_W'(lafc_pkg::RST_LIM);
      lim2_r <= CNT_W'(lafc_pkg::RST_LIM);
      tevt_r <= lafc_pkg::RST_TEVT;
      ctrl_r <= lafc_pkg::RST_CTRL;
      mctl_r <= lafc_pkg::RST_STAT[7:0];
    end else begin
      if (wr_lim0) lim0_r <= wr_data[CNT_W-1:0];
      if (wr_lim1) lim1_r <= wr_data[CNT_W-1:0];
      if (wr_lim2) lim2_r <= wr_data[CNT_W-1:0];
      if (wr_tevt) tevt_r <= wr_data[15:0];
      if (wr_ctrl) ctrl_r <= wr_data[16:0];
      // Clear bits are not stored and read back as zero
      if (wr_stat) mctl_r <= wr_data[7:0] & 8'hAF;
    end
  end

  // ***********************************************
  // Field decode
  // ***********************************************
  logic       enh;
  logic [1:0] csrc;
  logic [1:0] bmode;
  logic [2:0] bfcs;
  logic [2:0] sfcs;
  logic       wallow;
  logic       sec_lock;
  logic       pri_lock;
  logic       sec_en;
  logic       pri_dis;
  logic [1:0] dsel;

  assign enh      = ctrl_r[lafc_pkg::CT_ENH];
  assign csrc     = ctrl_r[lafc_pkg::CT_CSRC_LO +: 2];
  assign bmode    = ctrl_r[lafc_pkg::CT_BMOD_LO +: 2];
  assign bfcs     = ctrl_r[lafc_pkg::CT_BFCS_LO +: 3];
  assign sfcs     = ctrl_r[lafc_pkg::CT_SFCS_LO +: 3];
  assign wallow   = ctrl_r[lafc_pkg::CT_WALLOW];
  assign sec_lock = mctl_r[lafc_pkg::ST_SLOCK];
  assign pri_lock = mctl_r[lafc_pkg::ST_PLOCK];
  assign sec_en   = mctl_r[lafc_pkg::ST_SEN];
  assign pri_dis  = mctl_r[lafc_pkg::ST_PDIS];
  assign dsel     = mctl_r[lafc_pkg::ST_DSEL_LO +: 2];

  // ***********************************************
  // Tick source and counters
  // ***********************************************
  logic tick;

  assign tick = (csrc == lafc_pkg::CSRC_LCD)  ? lcd_tick_i :
                (csrc == lafc_pkg::CSRC_RTC)  ? rtc_tick_i :
                (csrc == lafc_pkg::CSRC_LOG1) ? logic1_tick_i :
                                                logic2_tick_i;

  logic ovf0;
  logic ovf1;
  logic ovf2;
  logic tev_ovf;

  lafc_frame_counter #(.W(CNT_W)) u_cnt0 (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .en_i     (enh),
    .tick_i   (tick),
    .limit_i  (lim0_r),
    .ovf_o    (ovf0)
  );

  lafc_frame_counter #(.W(CNT_W)) u_cnt1 (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .en_i     (enh),
    .tick_i   (tick),
    .limit_i  (lim1_r),
    .ovf_o    (ovf1)
  );

  lafc_frame_counter #(.W(CNT_W)) u_cnt2 (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .en_i     (enh),
    .tick_i   (tick),
    .limit_i  (lim2_r),
    .ovf_o    (ovf2)
  );

  // Time event counter shares the selected tick
  lafc_frame_counter #(.W(16)) u_tevt (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .en_i     (enh),
    .tick_i   (tick),
    .limit_i  (tevt_r),
    .ovf_o    (tev_ovf)
  );

  // ***********************************************
  // Switchover pacing
  // ***********************************************
  logic phase_r;
  logic pace;

  // Phase picks counter 1 after a time event in the 010 pattern and flips on each time event in the 100 pattern
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      phase_r <= 1'b0;
    end else if (!enh || wr_ctrl) begin
      phase_r <= 1'b0;
    end else if (tev_ovf) begin
      phase_r <= (sfcs == lafc_pkg::FCS_ALT) ? ~phase_r : (sfcs == lafc_pkg::FCS_C0C1);
    end
  end

  assign pace = (sfcs == lafc_pkg::FCS_C0)                                 ? ovf0 :
                (sfcs == lafc_pkg::FCS_C0C1 || sfcs == lafc_pkg::FCS_ALT)  ? (phase_r ? ovf1 : ovf0) :
                                                                             1'b0;

  // ***********************************************
  // Display source selection
  // ***********************************************
  logic disp_sec_r;
  logic once_done_r;
  logic disp_nxt;
  logic once_nxt;

  always_comb begin
    disp_nxt = disp_sec_r;
    once_nxt = once_done_r;
    case (dsel)
      lafc_pkg::DSEL_PRI: begin
        disp_nxt = 1'b0;
        once_nxt = 1'b0;
      end
      lafc_pkg::DSEL_SEC: begin
        disp_nxt = 1'b1;
        once_nxt = 1'b0;
      end
      lafc_pkg::DSEL_ONCE: begin
        if (enh && pace && !once_done_r) begin
          disp_nxt = ~disp_sec_r;
          once_nxt = 1'b1;
        end
      end
      lafc_pkg::DSEL_ALT: begin
        once_nxt = 1'b0;
        if (enh && pace) begin
          disp_nxt = ~disp_sec_r;
        end
      end
      default: begin
        disp_nxt = 1'b0;
        once_nxt = 1'b0;
      end
    endcase
    // A disabled secondary memory can never be shown
    if (!sec_en) begin
      disp_nxt = 1'b0;
    end
    // Rewriting the select rearms the single switchover
    if (wr_stat) begin
      once_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      disp_sec_r  <= 1'b0;
      once_done_r <= 1'b0;
    end else begin
      disp_sec_r  <= disp_nxt;
      once_done_r <= once_nxt;
    end
  end

  // ***********************************************
  // Sticky status flags
  // ***********************************************
  logic blank_r;
  logic tevovf_r;
  logic c2ovf_r;
  logic c1ovf_r;
  logic c0ovf_r;
  logic blank_set;
  logic blank_hwclr;
  logic [15:0] sw_clr;

  assign sw_clr      = wr_stat ? wr_data[15:0] : 16'h0000;
  assign blank_set   = enh && tev_ovf && (bfcs == lafc_pkg::FCS_ONCE) &&
                       (bmode == lafc_pkg::BMOD_SEL || bmode == lafc_pkg::BMOD_ALL);
  assign blank_hwclr = (bmode == lafc_pkg::BMOD_OFF) || !enh;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      blank_r  <= 1'b0;
      tevovf_r <= 1'b0;
      c2ovf_r  <= 1'b0;
      c1ovf_r  <= 1'b0;
      c0ovf_r  <= 1'b0;
    end else begin
      // Held until software or the mode clears it
      blank_r  <= lafc_pkg::lafc_sticky(blank_r, blank_set,
                                         sw_clr[lafc_pkg::ST_BLANK] || blank_hwclr);
      tevovf_r <= lafc_pkg::lafc_sticky(tevovf_r, tev_ovf, sw_clr[lafc_pkg::ST_TEVOVF]);
      c2ovf_r  <= lafc_pkg::lafc_sticky(c2ovf_r, ovf2, sw_clr[lafc_pkg::ST_C2OVF]);
      c1ovf_r  <= lafc_pkg::lafc_sticky(c1ovf_r, ovf1, sw_clr[lafc_pkg::ST_C1OVF]);
      c0ovf_r  <= lafc_pkg::lafc_sticky(c0ovf_r, ovf0, sw_clr[lafc_pkg::ST_C0OVF]);
    end
  end

  // ***********************************************
  // Memory grants and outputs
  // ***********************************************
  logic pri_act;
  logic sec_act;
  logic pri_grant;
  logic sec_grant;

  assign sec_act   = disp_sec_r;
  assign pri_act   = !disp_sec_r && !pri_dis;
  assign sec_grant = sec_en && !sec_lock;
  assign pri_grant = !pri_dis && (sec_en ? !pri_lock : wallow);

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      primary_write_grant_o    <= 1'b0;
      secondary_write_grant_o  <= 1'b0;
      primary_clear_o          <= 1'b0;
      secondary_clear_o        <= 1'b0;
      display_from_secondary_o <= 1'b0;
      enhanced_irq_o           <= 1'b0;
    end else begin
      primary_write_grant_o    <= pri_grant;
      secondary_write_grant_o  <= sec_grant;
      primary_clear_o          <= wr_stat && wr_data[lafc_pkg::ST_PCLR];
      secondary_clear_o        <= wr_stat && wr_data[lafc_pkg::ST_SCLR];
      display_from_secondary_o <= disp_sec_r;
      enhanced_irq_o           <= blank_r;
    end
  end

  // ***********************************************
  // Read mux
  // ***********************************************
  logic [15:0] stat_rd;

  // Bit 15 unimplemented
  assign stat_rd = {1'b0, blank_r, sec_act, pri_act, tevovf_r, c2ovf_r, c1ovf_r, c0ovf_r,
                    mctl_r};

  assign rd_data = (rd_addr == lafc_pkg::OFS_STAT) ? {16'h0000, stat_rd} :
                   (rd_addr == lafc_pkg::OFS_LIM0) ? 32'(lim0_r) :
                   (rd_addr == lafc_pkg::OFS_LIM1) ? 32'(lim1_r) :
                   (rd_addr == lafc_pkg::OFS_LIM2) ? 32'(lim2_r) :
                   (rd_addr == lafc_pkg::OFS_CTRL) ? {15'h0000, ctrl_r} :
                   (rd_addr == lafc_pkg::OFS_TEVT) ? {16'h0000, tevt_r} :
                                                     32'h00000000;

endmodule // lafc_top

// ---- core/lafc_pkg.sv ----
// Purpose: Shared constants for the LCD animation status and frame-counter block
// Assumes: 32-bit AHB-Lite register words, 16-bit register contents except the 17-bit control register
// Notes:   Offsets are byte addresses

// ***********************************************
// Package
// ***********************************************
package lafc_pkg;

  localparam int unsigned DATA_W = 16;

  // Register byte offsets
  localparam logic [7:0] OFS_STAT  = 8'h00;
  localparam logic [7:0] OFS_LIM0  = 8'h04;
  localparam logic [7:0] OFS_LIM1  = 8'h08;
  localparam logic [7:0] OFS_LIM2  = 8'h0C;
  localparam logic [7:0] OFS_CTRL  = 8'h10;
  localparam logic [7:0] OFS_TEVT  = 8'h14;

  // Status/control register fields
  localparam int unsigned ST_BLANK   = 14;
  localparam int unsigned ST_SECACT  = 13;
  localparam int unsigned ST_PRIACT  = 12;
  localparam int unsigned ST_TEVOVF  = 11;
  localparam int unsigned ST_C2OVF   = 10;
  localparam int unsigned ST_C1OVF   = 9;
  localparam int unsigned ST_C0OVF   = 8;
  localparam int unsigned ST_SLOCK   = 7;
  localparam int unsigned ST_SCLR    = 6;
  localparam int unsigned ST_PLOCK   = 5;
  localparam int unsigned ST_PCLR    = 4;
  localparam int unsigned ST_SEN     = 3;
  localparam int unsigned ST_PDIS    = 2;
  localparam int unsigned ST_DSEL_LO = 0;

  // Control register fields
  localparam int unsigned CT_ENH     = 0;
  localparam int unsigned CT_CSRC_LO = 1;
  localparam int unsigned CT_BMOD_LO = 3;
  localparam int unsigned CT_BFCS_LO = 5;
  localparam int unsigned CT_SFCS_LO = 13;
  localparam int unsigned CT_WALLOW  = 16;

  // Reset values
  localparam logic [15:0] RST_STAT = 16'h0000;
  localparam logic [16:0] RST_CTRL = 17'h00000;
  localparam logic [15:0] RST_LIM  = 16'h0000;
  localparam logic [15:0] RST_TEVT = 16'h0000;

  // Field encodings
  localparam logic [1:0] DSEL_PRI  = 2'h0;
  localparam logic [1:0] DSEL_SEC  = 2'h1;
  localparam logic [1:0] DSEL_ONCE = 2'h2;
  localparam logic [1:0] DSEL_ALT  = 2'h3;
  localparam logic [1:0] BMOD_OFF  = 2'h0;
  localparam logic [1:0] BMOD_SEL  = 2'h1;
  localparam logic [1:0] BMOD_ALL  = 2'h2;
  localparam logic [2:0] FCS_C0    = 3'h1;
  localparam logic [2:0] FCS_C0C1  = 3'h2;
  localparam logic [2:0] FCS_ALT   = 3'h4;
  localparam logic [2:0] FCS_ONCE  = 3'h6;
  localparam logic [1:0] CSRC_LCD  = 2'h0;
  localparam logic [1:0] CSRC_RTC  = 2'h1;
  localparam logic [1:0] CSRC_LOG1 = 2'h2;
  localparam logic [1:0] CSRC_LOG2 = 2'h3;

  // AHB encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  // Bus slave states
  typedef enum logic [1:0] {
    LAFC_BUS_IDLE  = 2'b01,
    LAFC_BUS_RDWAIT = 2'b10
  } lafc_bus_t;

  // Sticky flag update; a hardware set wins over a software clear
  function automatic logic lafc_sticky(input logic cur, input logic set, input logic clr);
    return set | (cur & ~clr);
  endfunction

endpackage

// ---- core/lafc_frame_counter.sv ----
// Purpose: One overflow counter paced by a selected tick
// Assumes: tick_i is a one-cycle pulse synchronous to clk_i
// Notes:   Limit is the period in ticks; counter restarts at zero

`timescale 1ns/1ps

module lafc_frame_counter #(
  parameter int unsigned W = 16
) (
  input  wire logic         clk_i,
  input  wire logic         arst_n_i,
  input  wire logic         en_i,
  input  wire logic         tick_i,
  input  wire logic [W-1:0] limit_i,
  output logic              ovf_o
);

  logic [W-1:0] cnt_r;
  logic [W:0]   cnt_inc;
  logic         wrap;

  assign cnt_inc = {1'b0, cnt_r} + {{W{1'b0}}, 1'b1};
  // Compare with >= so a lowered limit cannot strand the count
  assign wrap    = tick_i && (cnt_inc >= {1'b0, limit_i});

  // ***********************************************
  // Count and overflow
  // ***********************************************
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_r <= '0;
      ovf_o <= 1'b0;
    end else if (!en_i) begin
      cnt_r <= '0;
      ovf_o <= 1'b0;
    end else begin
      ovf_o <= wrap;
      if (wrap) begin
        cnt_r <= '0;
      end else if (tick_i) begin
        cnt_r <= cnt_inc[W-1:0];
      end
    end
  end

endmodule // lafc_frame_counter

// ---- core/lafc_ahb_slave.sv ----
// Purpose: AHB-Lite slave front end, word registers only
// Assumes: Single transfers; writes zero wait, reads one wait state
// Notes:   Response is always OKAY

`timescale 1ns/1ps

module lafc_ahb_slave (
  input  wire logic        clk_i,
  input  wire logic        arst_n_i,
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic        hready_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic [31:0] rd_data_i,
  output logic [7:0]       rd_addr_o,
  output logic             wr_stb_o,
  output logic [7:0]       wr_addr_o,
  output logic [31:0]      wr_data_o,
  output logic [31:0]      hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o
);

  lafc_pkg::lafc_bus_t state_r;
  logic                 take;
  logic                 wr_pend_r;

  assign take      = hsel_i && hready_i && htrans_i[1];
  assign wr_stb_o  = wr_pend_r;
  assign wr_data_o = hwdata_i;

  // ***********************************************
  // Phase tracking
  // ***********************************************
  // Read waits a cycle so a write just before it is already visible
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_r     <= lafc_pkg::LAFC_BUS_IDLE;
      wr_pend_r   <= 1'b0;
      wr_addr_o   <= 8'h00;
      rd_addr_o   <= 8'h00;
      hrdata_o    <= 32'h00000000;
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
    end else begin
      wr_pend_r <= take && hwrite_i;
      case (state_r)
        lafc_pkg::LAFC_BUS_IDLE: begin
          if (take) begin
            wr_addr_o <= haddr_i[7:0];
            rd_addr_o <= haddr_i[7:0];
          end
          if (take && !hwrite_i) begin
            state_r     <= lafc_pkg::LAFC_BUS_RDWAIT;
            hreadyout_o <= 1'b0;
          end
        end
        lafc_pkg::LAFC_BUS_RDWAIT: begin
          hrdata_o    <= rd_data_i;
          hreadyout_o <= 1'b1;
          state_r     <= lafc_pkg::LAFC_BUS_IDLE;
        end
        default: begin
          state_r     <= lafc_pkg::LAFC_BUS_IDLE;
          hreadyout_o <= 1'b1;
        end
      endcase
    end
  end

endmodule // lafc_ahb_slave

// ---- dv/lafc_monitor.sv ----
// Purpose: Bus timing and memory-control checks
// Assumes: One slave, hready looped back
// Notes:   Sees top-level ports only
`timescale 1ns/1ps
module lafc_monitor (
  input logic        clk_i,
  input logic        arst_n_i,
  input logic        hsel_i,
  input logic [31:0] haddr_i,
  input logic [1:0]  htrans_i,
  input logic        hwrite_i,
  input logic        hready_i,
  input logic [31:0] hwdata_i,
  input logic        hreadyout_o,
  input logic        primary_write_grant_o,
  input logic        secondary_write_grant_o,
  input logic        primary_clear_o,
  input logic        secondary_clear_o,
  input logic        display_from_secondary_o
);
  // ********
  // Helpers
  // ********
  logic tk;
  logic stw_r;
  assign tk = hsel_i & hready_i & htrans_i[1];
  // Marks the data phase of a status write
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) stw_r <= 1'b0;
    else stw_r <= tk & hwrite_i & (haddr_i[7:0] == 8'h00);
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  // ********
  // Checks
  // ********
  chk_read_wait:
    assert property (tk && !hwrite_i |=> !hreadyout_o ##1 hreadyout_o) else $error("read wait wrong");
  chk_write_nowait:
    assert property (tk && hwrite_i |=> hreadyout_o) else $error("write stalled");
  chk_pri_clear:
    assert property (stw_r && hwdata_i[4] |=> primary_clear_o ##1 !primary_clear_o) else $error("pri clear");
  chk_sec_clear:
    assert property (stw_r && hwdata_i[6] |=> secondary_clear_o ##1 !secondary_clear_o) else $error("sec clear");
  chk_sec_lock:
    assert property (stw_r && hwdata_i[7] |=> ##1 !secondary_write_grant_o) else $error("sec lock");
  chk_pri_lock:
    assert property (stw_r && hwdata_i[5] && hwdata_i[3] |=> ##1 !primary_write_grant_o) else $error("pri lock");
  // Display source needs one more cycle than the grants: select, then output flop
  chk_sec_off:
    assert property (stw_r && !hwdata_i[3] |=> ##2 !secondary_write_grant_o && !display_from_secondary_o)
      else $error("sec disabled");
  chk_pri_disable:
    assert property (stw_r && hwdata_i[2] |=> ##1 !primary_write_grant_o) else $error("pri disable");
  chk_sec_select:
    assert property (stw_r && hwdata_i[3:0] == 4'h9 |=> ##2 display_from_secondary_o) else $error("select");
endmodule // lafc_monitor

bind lafc_top lafc_monitor i_mon (.*);

// ---- dv/lafc_top_tb.sv ----
// Purpose: Self-checking bench for lafc_top
// Assumes: Single AHB master, hready looped back
// Notes:   Frame ticks pulsed by hand, limits kept small except counter 1 at FFFF
`timescale 1ns/1ps
module lafc_top_tb;
  typedef struct {
    logic [7:0]  a;
    logic [31:0] d;
    logic [31:0] e;
    logic [2:0]  o;
  } lafc_row_t;
  logic        clk_i = 1'b0;
  logic        arst_n_i = 1'b0;
  logic        hwrite_i = 1'b0;
  logic        tick = 1'b0;
  logic [3:0]  tsrc = 4'h1;
  logic [1:0]  htrans_i = 2'h0;
  logic [31:0] haddr_i = 32'h0;
  logic [31:0] hwdata_i = 32'h0;
  logic [31:0] hrdata_o;
  logic [31:0] rdat;
  logic        hready, hresp_o, pg, sg, pc, sc, ds, irq;
  int          n_mismatch = 0;
  int          num_checks = 0;
  // Outputs expected after each row: grant primary, grant secondary, display
  lafc_row_t rows [10] = '{
    '{8'h04, 32'h3, 32'h3, 3'h0}, '{8'h08, 32'hFFFF, 32'hFFFF, 3'h0},
    '{8'h0C, 32'h4, 32'h4, 3'h0}, '{8'h14, 32'h5, 32'h5, 3'h0},
    '{8'h10, 32'h1FFE0, 32'h1FFE0, 3'h4}, '{8'h00, 32'h9, 32'h2009, 3'h7},
    '{8'h00, 32'hA8, 32'h10A8, 3'h0}, '{8'h00, 32'h4, 32'h4, 3'h0},
    '{8'h00, 32'h1, 32'h1001, 3'h4}, '{8'h18, 32'h1234, 32'h0, 3'h4}};

  lafc_top i_dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .hsel_i(1'b1), .haddr_i(haddr_i),
    .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2), .hready_i(hready), .hwdata_i(hwdata_i),
    .hrdata_o(hrdata_o), .hreadyout_o(hready), .hresp_o(hresp_o), .lcd_tick_i(tick & tsrc[0]),
    .rtc_tick_i(tick & tsrc[1]), .logic1_tick_i(tick & tsrc[2]), .logic2_tick_i(tick & tsrc[3]),
    .primary_write_grant_o(pg), .secondary_write_grant_o(sg),
    .primary_clear_o(pc), .secondary_clear_o(sc), .display_from_secondary_o(ds), .enhanced_irq_o(irq));

  initial forever #5 clk_i = ~clk_i;
  // ********
  // Tasks
  // ********
  task automatic results();
    if (n_mismatch == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask
  // Bounded wait for hready; read data taken at the same edge
  task automatic wt();
    int i;
    for (i = 0; i < 20; i++) begin
      @(negedge clk_i);
      rdat = hrdata_o;
      if (hready === 1'b1) break;
    end
    if (i == 20) begin
      chk(32'h0, 32'h1);
      results();
    end else @(posedge clk_i);
  endtask
  task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] d);
    htrans_i <= 2'h2;
    haddr_i  <= {24'h0, a};
    hwrite_i <= w;
    wt();
    htrans_i <= 2'h0;
    hwdata_i <= d;
    wt();
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    ahb(a, 1'b0, 32'h0);
    chk(rdat, e);
  endtask
  task automatic ticks(input int n);
    repeat (n) begin
      tick <= 1'b1;
      @(posedge clk_i);
      tick <= 1'b0;
      @(posedge clk_i);
    end
    repeat (4) @(posedge clk_i);
  endtask
  // ********
  // Sequence
  // ********
  initial begin
    repeat (2) @(posedge clk_i);
    chk({24'h0, hready, hresp_o, pg, sg, pc, sc, ds, irq}, 32'h80);
    arst_n_i <= 1'b1;
    @(posedge clk_i);
    foreach (rows[k]) begin
      // Limits above two, written while enhancement is off
      ahb(rows[k].a, 1'b1, rows[k].d);
      rd(rows[k].a, rows[k].e);
      chk({29'h0, pg, sg, ds}, {29'h0, rows[k].o});
    end
    ahb(8'h00, 1'b1, 32'h51);
    @(negedge clk_i);
    chk({30'h0, pc, sc}, 32'h3);
    @(posedge clk_i);
    rd(8'h00, 32'h1001);
    ahb(8'h10, 1'b1, 32'h10001);
    ticks(4);
    rd(8'h00, 32'h1501);
    ahb(8'h00, 1'b1, 32'h501);
    rd(8'h00, 32'h1001);
    ticks(1);
    rd(8'h00, 32'h1801);
    ahb(8'h10, 1'b1, 32'h100C9);
    ticks(5);
    rd(8'h00, 32'h5D01);
    chk({31'h0, irq}, 32'h1);
    ahb(8'h00, 1'b1, 32'h4001);
    rd(8'h00, 32'h1D01);
    chk({31'h0, irq}, 32'h0);
    ticks(5);
    chk({31'h0, irq}, 32'h1);
    ahb(8'h10, 1'b1, 32'h10001);
    repeat (3) @(posedge clk_i);
    chk({31'h0, irq}, 32'h0);
    ahb(8'h00, 1'b0, 32'h0);
    chk(rdat & 32'h4000, 32'h0);
    // Switchover paced by counter 0; only the second source may count
    ahb(8'h00, 1'b1, 32'h0B);
    ahb(8'h10, 1'b1, 32'h12002);
    ahb(8'h10, 1'b1, 32'h12003);
    ticks(3);
    chk({31'h0, ds}, 32'h0);
    tsrc <= 4'h2;
    ticks(3);
    chk({31'h0, ds}, 32'h1);
    ticks(3);
    chk({31'h0, ds}, 32'h0);
    ahb(8'h00, 1'b1, 32'h0A);
    ticks(3);
    chk({31'h0, ds}, 32'h1);
    ticks(3);
    chk({31'h0, ds}, 32'h1);
    results();
  end
endmodule // lafc_top_tb
